/* File: design/two_stage_watchdog_timer.sv */
`timescale 1ns/1ps
// Clocked from whichever source the integration feeds to clk_i
module two_stage_watchdog_timer #(
	parameter int CNT_W        = 32,
	parameter int RESET_CYCLES = watchdog_pkg::RESET_PULSE_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire logic        dbg_halt_i,
	output logic             irq_o,
	output logic             nmi_o,
	output logic             sys_reset_o
);

	typedef struct packed {
		watchdog_pkg::stage_t stage;
		logic [CNT_W-1:0]     load;
		logic                 rst_en;
		logic                 nmi;
		logic                 stall_en;
		logic                 locked;
		logic [31:0]          rdata;
	} wdt_state_t;

	wdt_state_t s_q;
	wdt_state_t s_d;

	logic             running;
	logic             run;
	logic             cnt_load;
	logic             timeout;
	logic             second;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] load_next;
	logic             wr_load;
	logic             wr_ctrl;
	logic             wr_clear;
	logic             wr_lock;
	logic             start;
	logic             int_raw;
	logic             int_mask;

	assign running   = (s_q.stage != watchdog_pkg::ST_OFF);
	assign run       = running & ~(s_q.stall_en & dbg_halt_i);
	assign wr_load   = wr_i & (addr_i == watchdog_pkg::OFS_LOAD) & ~s_q.locked;
	assign wr_ctrl   = wr_i & (addr_i == watchdog_pkg::OFS_CTRL) & ~s_q.locked;
	assign wr_clear  = wr_i & (addr_i == watchdog_pkg::OFS_INT_CLEAR) & ~s_q.locked;
	assign wr_lock   = wr_i & (addr_i == watchdog_pkg::OFS_LOCK);
	assign start     = wr_ctrl & wdata_i[watchdog_pkg::CTRL_ENABLE] & ~running;
	assign load_next = wr_load ? wdata_i[CNT_W-1:0] : s_q.load;
	assign cnt_load  = start | (wr_load & running);
	assign second    = timeout & (s_q.stage == watchdog_pkg::ST_WARNED) & s_q.rst_en;
	assign int_raw   = (s_q.stage == watchdog_pkg::ST_WARNED);
	assign int_mask  = int_raw & running;
	assign irq_o     = int_mask & ~s_q.nmi;
	assign nmi_o     = int_mask & s_q.nmi;
	assign rdata_o   = s_q.rdata;

	wdt_down_counter #(
		.WIDTH      (CNT_W)
	) u_counter (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.load_i     (cnt_load),
		.run_i      (run),
		.load_val_i (load_next),
		.count_o    (count),
		.timeout_o  (timeout)
	);

	wdt_reset_pulse #(
		.CYCLES  (RESET_CYCLES)
	) u_reset (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.trig_i  (second),
		.pulse_o (sys_reset_o)
	);

	always_comb
	begin
		s_d = s_q;
		if (wr_load)
		begin
			s_d.load = wdata_i[CNT_W-1:0];
		end
		if (wr_ctrl)
		begin
			s_d.rst_en   = wdata_i[watchdog_pkg::CTRL_RESET_EN];
			s_d.nmi      = wdata_i[watchdog_pkg::CTRL_NMI];
			s_d.stall_en = wdata_i[watchdog_pkg::CTRL_STALL_EN];
		end
		if (wr_lock)
		begin
			s_d.locked = (wdata_i != watchdog_pkg::UNLOCK_KEY);
		end
		// Timeout beats a clear in the same cycle so no event is lost
		case (s_q.stage)
			watchdog_pkg::ST_OFF:
			begin
				if (start)
				begin
					s_d.stage = watchdog_pkg::ST_COUNT;
				end
			end
			watchdog_pkg::ST_COUNT:
			begin
				if (timeout)
				begin
					s_d.stage = watchdog_pkg::ST_WARNED;
				end
			end
			watchdog_pkg::ST_WARNED:
			begin
				if (wr_clear && !timeout)
				begin
					s_d.stage = watchdog_pkg::ST_COUNT;
				end
			end
			default:
			begin
				s_d.stage = watchdog_pkg::ST_OFF;
			end
		endcase
		s_d.rdata = 32'h0000_0000;
		if (rd_i)
		begin
			case (addr_i)
				watchdog_pkg::OFS_LOAD:        s_d.rdata = 32'(s_q.load);
				watchdog_pkg::OFS_VALUE:       s_d.rdata = 32'(count);
				watchdog_pkg::OFS_CTRL:
				begin
					s_d.rdata[watchdog_pkg::CTRL_ENABLE]   = running;
					s_d.rdata[watchdog_pkg::CTRL_RESET_EN] = s_q.rst_en;
					s_d.rdata[watchdog_pkg::CTRL_NMI]      = s_q.nmi;
					s_d.rdata[watchdog_pkg::CTRL_STALL_EN] = s_q.stall_en;
				end
				watchdog_pkg::OFS_RAW_STATUS:  s_d.rdata[0] = int_raw;
				watchdog_pkg::OFS_MASK_STATUS: s_d.rdata[0] = int_mask;
				watchdog_pkg::OFS_LOCK:        s_d.rdata[0] = s_q.locked;
				default:                       s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s_q.stage    <= watchdog_pkg::ST_OFF;
			s_q.load     <= watchdog_pkg::LOAD_RESET[CNT_W-1:0];
			s_q.rst_en   <= 1'b0;
			s_q.nmi      <= 1'b0;
			s_q.stall_en <= 1'b0;
			s_q.locked   <= 1'b0;
			s_q.rdata    <= 32'h0000_0000;
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule : two_stage_watchdog_timer

/* File: design/watchdog_pkg.sv */
// Contract
// - 32-bit down counter from software load value
// - Zero after enable gives first timeout; enable sticks
// - Each timeout reloads counter and keeps counting
// - Interrupt first; reset on second uncleared timeout
// - Load write while running reloads counter at once
// - Lock blocks enable, interrupt, clear, configuration writes
// - Software clear drops the interrupt source
// - Optional NMI delivery, still enabled and cleared
// - Raw and masked status readable, 1 active
// - Instance clock is system or precision oscillator
// - Zero load value interrupts immediately
// - Second-timeout reset selectable, frozen while locked
// - Debug stall option holds counter during halt
// - Lock state, count and load value readable
package watchdog_pkg;

	localparam int          DATA_W          = 32;
	localparam int          ADDR_W          = 8;

	localparam logic [7:0]  OFS_LOAD        = 8'h00;
	localparam logic [7:0]  OFS_VALUE       = 8'h04;
	localparam logic [7:0]  OFS_CTRL        = 8'h08;
	localparam logic [7:0]  OFS_INT_CLEAR   = 8'h0C;
	localparam logic [7:0]  OFS_RAW_STATUS  = 8'h10;
	localparam logic [7:0]  OFS_MASK_STATUS = 8'h14;
	localparam logic [7:0]  OFS_LOCK        = 8'h18;

	localparam int          CTRL_ENABLE     = 0;
	localparam int          CTRL_RESET_EN   = 1;
	localparam int          CTRL_NMI        = 2;
	localparam int          CTRL_STALL_EN   = 3;

	// Arbitrary unlock key value
	localparam logic [31:0] UNLOCK_KEY      = 32'h5A5A_5A5A;

	localparam logic [31:0] LOAD_RESET      = 32'hFFFF_FFFF;
	localparam logic [31:0] COUNT_RESET     = 32'hFFFF_FFFF;
	localparam int          RESET_PULSE_CYCLES = 16;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_COUNT,
		ST_WARNED
	} stage_t;

endpackage : watchdog_pkg

/* File: design/wdt_down_counter.sv */
`timescale 1ns/1ps
module wdt_down_counter #(
	parameter int WIDTH = 32
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             load_i,
	input  wire logic             run_i,
	input  wire logic [WIDTH-1:0] load_val_i,
	output logic      [WIDTH-1:0] count_o,
	output logic                  timeout_o
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
	} cnt_state_t;

	cnt_state_t s_q;
	cnt_state_t s_d;

	logic zero;

	assign zero      = (s_q.count == '0);
	assign timeout_o = run_i & zero & ~load_i;
	assign count_o   = s_q.count;

	always_comb
	begin
		s_d = s_q;
		if (load_i)
		begin
			s_d.count = load_val_i;
		end
		else if (run_i)
		begin
			if (zero)
			begin
				s_d.count = load_val_i;
			end
			else
			begin
				s_d.count = s_q.count - {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s_q.count <= watchdog_pkg::COUNT_RESET[WIDTH-1:0];
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule : wdt_down_counter

/* File: design/wdt_reset_pulse.sv */
`timescale 1ns/1ps
module wdt_reset_pulse #(
	parameter int CYCLES = 16
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic trig_i,
	output logic      pulse_o
);

	// Stretched so slow reset logic cannot miss a one-cycle event
	typedef struct packed {
		logic [15:0] left;
		logic        pulse;
	} pulse_state_t;

	pulse_state_t s_q;
	pulse_state_t s_d;

	assign pulse_o = s_q.pulse;

	always_comb
	begin
		s_d = s_q;
		if (trig_i)
		begin
			s_d.left  = 16'(CYCLES - 1);
			s_d.pulse = 1'b1;
		end
		else if (s_q.left != 16'h0000)
		begin
			s_d.left = s_q.left - 16'h0001;
		end
		else
		begin
			s_d.pulse = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s_q.left  <= 16'h0000;
			s_q.pulse <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule : wdt_reset_pulse

/* File: testbench/two_stage_watchdog_timer_test.sv */
`timescale 1ns/1ps
module two_stage_watchdog_timer_test;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        halt_req = 1'b0;
	logic [31:0] rdata_o;
	logic [31:0] v;
	logic        dbg_halt_i, irq_o, nmi_o, sys_reset_o;
	int          resets;
	int          mismatches = 0;
	int          samples_checked = 0;
	always #2 clk_i = ~clk_i;
	two_stage_watchdog_timer #(.CNT_W(32), .RESET_CYCLES(3)) dut_u (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .dbg_halt_i(dbg_halt_i), .irq_o(irq_o),
		.nmi_o(nmi_o), .sys_reset_o(sys_reset_o));
	wdt_host_model host_u (.clk_i(clk_i), .halt_req_i(halt_req), .sys_reset_i(sys_reset_o),
		.dbg_halt_o(dbg_halt_i), .resets_o(resets));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		rd(a, v);
		samples_checked++;
		if (v !== e)
		begin
			mismatches++;
			$display("wrong value at %0t: reg %h read %h", $time, a, v);
		end
	endtask : chk
	task automatic chk_pin(input logic g, input logic e);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value at %0t: pin level", $time);
		end
	endtask : chk_pin
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	// Whole run is well under a thousand cycles
	initial
	begin
		#40000;
		mismatches++;
		stop_test();
	end
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		chk(watchdog_pkg::OFS_LOAD, watchdog_pkg::LOAD_RESET);
		chk(watchdog_pkg::OFS_VALUE, watchdog_pkg::COUNT_RESET);
		chk(watchdog_pkg::OFS_CTRL, 32'h0);
		chk(8'h1C, 32'h0);
		wr(watchdog_pkg::OFS_LOAD, 32'h28);
		wr(watchdog_pkg::OFS_CTRL, 32'h3);
		chk(watchdog_pkg::OFS_VALUE, 32'h27);
		chk(watchdog_pkg::OFS_CTRL, 32'h3);
		@(posedge clk_i);
		halt_req <= 1'b1;
		wr(watchdog_pkg::OFS_CTRL, 32'hB);
		chk(watchdog_pkg::OFS_VALUE, 32'h21);
		chk(watchdog_pkg::OFS_VALUE, 32'h21);
		wr(watchdog_pkg::OFS_CTRL, 32'h3);
		halt_req <= 1'b0;
		repeat (200) if (irq_o !== 1'b1) @(posedge clk_i);
		#1 chk_pin(irq_o, 1'b1);
		chk_pin(nmi_o, 1'b0);
		chk(watchdog_pkg::OFS_RAW_STATUS, 32'h1);
		chk(watchdog_pkg::OFS_MASK_STATUS, 32'h1);
		repeat (200) if (resets == 0) @(posedge clk_i);
		#1 chk_pin(resets == 1, 1'b1);
		wr(watchdog_pkg::OFS_LOAD, 32'h3E8);
		chk(watchdog_pkg::OFS_VALUE, 32'h3E7);
		wr(watchdog_pkg::OFS_INT_CLEAR, 32'h0);
		chk(watchdog_pkg::OFS_RAW_STATUS, 32'h0);
		wr(watchdog_pkg::OFS_LOCK, 32'h0);
		chk(watchdog_pkg::OFS_LOCK, 32'h1);
		wr(watchdog_pkg::OFS_LOAD, 32'h7);
		wr(watchdog_pkg::OFS_CTRL, 32'h4);
		chk(watchdog_pkg::OFS_LOAD, 32'h3E8);
		chk(watchdog_pkg::OFS_CTRL, 32'h3);
		wr(watchdog_pkg::OFS_LOCK, watchdog_pkg::UNLOCK_KEY);
		wr(watchdog_pkg::OFS_CTRL, 32'h5);
		wr(watchdog_pkg::OFS_LOAD, 32'h0);
		repeat (2) @(posedge clk_i);
		#1 chk_pin(nmi_o, 1'b1);
		chk_pin(irq_o, 1'b0);
		repeat (20) @(posedge clk_i);
		chk_pin(resets == 1, 1'b1);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		chk(watchdog_pkg::OFS_CTRL, 32'h0);
		chk_pin(nmi_o, 1'b0);
		stop_test();
	end
endmodule : two_stage_watchdog_timer_test

/* File: testbench/wdt_host_model.sv */
`timescale 1ns/1ps
// Core and reset logic: halt lags the request by a clock, as in a real core
module wdt_host_model (
	input  wire logic clk_i,
	input  wire logic halt_req_i,
	input  wire logic sys_reset_i,
	output logic      dbg_halt_o,
	output int        resets_o
);
	logic reset_q = 1'b0;
	initial dbg_halt_o = 1'b0;
	initial resets_o = 0;
	always @(posedge clk_i)
	begin
		dbg_halt_o <= halt_req_i;
		reset_q    <= sys_reset_i;
		if (sys_reset_i && !reset_q)
			resets_o <= resets_o + 1;
	end
endmodule : wdt_host_model

/* File: testbench/wdt_properties.sv */
`timescale 1ns/1ps
module wdt_checker #(
	parameter int RESET_CYCLES = 16
) (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        irq_o,
	input wire logic        nmi_o,
	input wire logic        sys_reset_o
);
	logic       lock_q;
	logic       nmi_q;
	logic       ren_q;
	logic [7:0] hi_q;
	wire        lk_w  = wr_i && addr_i == watchdog_pkg::OFS_LOCK;
	wire        ct_w  = wr_i && !lock_q && addr_i == watchdog_pkg::OFS_CTRL;
	wire        cl_w  = wr_i && !lock_q && addr_i == watchdog_pkg::OFS_INT_CLEAR;
	wire        int_w = irq_o || nmi_o;
	// Shadow of software state, so each output can be tied to its cause
	always_ff @(posedge clk_i)
	begin
		lock_q <= rst_n_i && (lk_w ? wdata_i != watchdog_pkg::UNLOCK_KEY : lock_q);
		nmi_q  <= rst_n_i && (ct_w ? wdata_i[watchdog_pkg::CTRL_NMI] : nmi_q);
		ren_q  <= rst_n_i && (ct_w ? wdata_i[watchdog_pkg::CTRL_RESET_EN] : ren_q);
		hi_q   <= (rst_n_i && sys_reset_o) ? hi_q + 8'h01 : 8'h00;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	int_route_a: assert property (int_w |-> nmi_o == nmi_q)
		else $error("interrupt on wrong line");
	int_hold_a: assert property (int_w && !wr_i |=> int_w)
		else $error("interrupt dropped");
	int_clear_a: assert property (cl_w |=> !int_w)
		else $error("clear ignored");
	reset_cause_a: assert property ($rose(sys_reset_o) |-> ren_q && $past(int_w))
		else $error("reset without cause");
	reset_length_a: assert property ($fell(sys_reset_o) |-> hi_q == RESET_CYCLES)
		else $error("reset pulse length");
	idle_read_a: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data outside slot");
	lock_read_a: assert property (rd_i && addr_i == watchdog_pkg::OFS_LOCK
		|=> rdata_o == {31'h0, lock_q})
		else $error("lock state wrong");
	raw_read_a: assert property (rd_i && addr_i == watchdog_pkg::OFS_RAW_STATUS
		|=> rdata_o == {31'h0, $past(int_w)})
		else $error("raw status wrong");
endmodule : wdt_checker
bind two_stage_watchdog_timer wdt_checker #(
	.RESET_CYCLES (RESET_CYCLES)
) checker_u (
	.clk_i        (clk_i),
	.rst_n_i      (rst_n_i),
	.addr_i       (addr_i),
	.wdata_i      (wdata_i),
	.wr_i         (wr_i),
	.rd_i         (rd_i),
	.rdata_o      (rdata_o),
	.irq_o        (irq_o),
	.nmi_o        (nmi_o),
	.sys_reset_o  (sys_reset_o)
);
